//--- hw/irq_accept_pkg.sv
package irq_accept_pkg;
  // ****************************************
  // widths and numbering
  // ****************************************
  localparam int NUM_LINES = 16;
  localparam int ADDR_W = 32;
  localparam logic [3:0] LINE_RESET = 4'h0;
  localparam logic [3:0] LINE_UNMASKABLE = 4'h1;
  localparam logic [3:0] FIRST_MASKABLE = 4'h4;
  // ****************************************
  // timing counts in cpu cycles
  // ****************************************
  localparam logic [4:0] OVERHEAD_FIXED = 5'h07;
  localparam logic [4:0] OVERHEAD_FLOAT = 5'h09;
  localparam logic [4:0] LATENCY_FIXED = 5'h0B;
  localparam logic [4:0] LATENCY_FLOAT = 5'h0D;
  localparam logic [4:0] LATENCY_RESET = 5'h15;
  localparam logic [4:0] FLAG_CLEAR_CYCLE = 5'h08;
  localparam logic [4:0] LATENCY_OFFSET = 5'h04;
  localparam logic [2:0] BRANCH_WINDOW = 3'h5;
  localparam logic [2:0] BRANCH_DELAY_SLOTS = 3'h5;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int VEC_INDEX_LSB = 5;
  localparam int VEC_BASE_LSB = 10;
  localparam logic [ADDR_W-1:0] RETURN_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PACKET_STEP = 32'h0000_0020;
  localparam int GIE_BIT = 0;
  localparam int SAVED_GLOBAL_ENABLE_BIT = 1;
  localparam int BRANCH_OFFSET_W = 21;
  localparam int NUM_PRED_REGS = 5;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ENTER = 2'b01,
    ST_RESET_ENTRY = 2'b10
  } seq_state_t;
endpackage : irq_accept_pkg

//--- hw/irq_accept.sv
`timescale 1ns/10ps
`default_nettype none
module irq_accept (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic float_variant_i,
  input wire logic [irq_accept_pkg::NUM_LINES-1:0] irq_line_i,
  input wire logic reset_vector_req_i,
  input wire logic mem_stall_i,
  input wire logic branch_in_e1_i,
  input wire logic multicycle_nop_i,
  input wire logic nop_first_cycle_i,
  input wire logic [irq_accept_pkg::ADDR_W-1:0] e1_packet_addr_i,
  input wire logic [irq_accept_pkg::ADDR_W-1:0] next_packet_addr_i,
  input wire logic ctl_wr_i,
  input wire logic [irq_accept_pkg::NUM_LINES-1:0] enable_mask_wr_data_i,
  input wire logic enable_mask_wr_i,
  input wire logic [irq_accept_pkg::NUM_LINES-1:0] flag_clear_reg_i,
  input wire logic flag_clear_wr_i,
  input wire logic [irq_accept_pkg::ADDR_W-1:0] return_ptr_wr_data_i,
  input wire logic return_ptr_wr_i,
  input wire logic [21:0] vec_base_wr_data_i,
  input wire logic vec_base_wr_i,
  input wire logic ret_maskable_i,
  input wire logic ret_unmaskable_i,
  input wire logic unmaskable_enable_set_i,
  input wire logic [irq_accept_pkg::NUM_PRED_REGS-1:0] pred_nonzero_i,
  input wire logic [2:0] pred_sel_i,
  input wire logic pred_invert_i,
  input wire logic [irq_accept_pkg::BRANCH_OFFSET_W-1:0] branch_disp_i,
  input wire logic [irq_accept_pkg::ADDR_W-1:0] branch_pc_i,
  output logic [irq_accept_pkg::NUM_LINES-1:0] pending_flag_reg_o,
  output logic [irq_accept_pkg::NUM_LINES-1:0] enable_mask_reg_o,
  output logic global_mask_enable_o,
  output logic saved_global_enable_o,
  output logic unmaskable_enable_o,
  output logic [irq_accept_pkg::ADDR_W-1:0] maskable_return_pointer_o,
  output logic [irq_accept_pkg::ADDR_W-1:0] unmaskable_return_pointer_o,
  output logic [irq_accept_pkg::ADDR_W-1:0] vector_table_pointer_o,
  output logic [irq_accept_pkg::ADDR_W-1:0] control_status_reg_o,
  output logic issue_hold_o,
  output logic annul_o,
  output logic force_branch_o,
  output logic [irq_accept_pkg::ADDR_W-1:0] force_target_o,
  output logic ack_o,
  output logic [3:0] ack_index_o,
  output logic service_start_o,
  output logic pred_true_o,
  output logic [irq_accept_pkg::ADDR_W-1:0] branch_target_o
);
  import irq_accept_pkg::*;

  // ****************************************
  // state
  // ****************************************
  seq_state_t state_ff, nxt_state;
  logic [4:0] cyc_ff, nxt_cyc;
  logic [3:0] idx_ff, nxt_idx;
  logic [NUM_LINES-1:0] line_prev_ff, nxt_line_prev;
  logic [NUM_LINES-1:0] flag_ff, nxt_flag;
  logic [NUM_LINES-1:0] ier_ff, nxt_ier;
  logic gie_ff, nxt_gie;
  logic saved_global_enable_ff, nxt_saved_global_enable;
  logic unmaskable_enable_ff, nxt_unmaskable_enable;
  logic in_nmi_ff, nxt_in_nmi;
  logic [ADDR_W-1:0] irp_ff, nxt_irp;
  logic [ADDR_W-1:0] nrp_ff, nxt_nrp;
  logic [21:0] vbase_ff, nxt_vbase;
  logic [2:0] br_hist_ff, nxt_br_hist;
  logic [2:0] slot_ff, nxt_slot;
  logic [ADDR_W-1:0] tgt_ff, nxt_tgt;
  logic fbr_ff, nxt_fbr;
  logic ack_ff, nxt_ack;
  logic svc_ff, nxt_svc;
  logic [ADDR_W-1:0] btgt_ff, nxt_btgt;
  logic pred_ff, nxt_pred;

  // ****************************************
  // edge detect and priority
  // ****************************************
  logic [NUM_LINES-1:0] rise;
  logic [NUM_LINES-1:0] ready;
  logic [3:0] hp_idx;
  logic hp_valid;
  logic [3:0] poll_idx;
  logic poll_valid;
  logic branch_busy;
  logic accept;
  logic [4:0] overhead;
  logic [4:0] latency;

  // a flag sets only on a low-to-high step, so one line fires every other cycle at most
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      assign rise[g] = irq_line_i[g] & ~line_prev_ff[g];
      // maskable lines also need the global enable; line 1 needs only its mask bit and the unmaskable enable
      assign ready[g] = flag_ff[g] & ier_ff[g] & unmaskable_enable_ff &
        ((g < int'(FIRST_MASKABLE)) | gie_ff);
    end
  endgenerate

  // lowest number from line 1 up wins; scan from the top so the last hit is the lowest
  // polling view ignores both enables: software polls while they are off
  always_comb begin
    hp_idx = 4'h0;
    hp_valid = 1'b0;
    poll_idx = 4'h0;
    poll_valid = 1'b0;
    for (int i = NUM_LINES - 1; i > 0; i--) begin
      if (ready[i]) begin
        hp_idx = 4'(i);
        hp_valid = 1'b1;
      end
      if (flag_ff[i] & ier_ff[i]) begin
        poll_idx = 4'(i);
        poll_valid = 1'b1;
      end
    end
  end

  // branch in execute now or in any of the last three packets, or its delay slots still open
  assign branch_busy = (br_hist_ff != 3'h0) | (slot_ff != 3'h0) | branch_in_e1_i;
  // acceptance looks only at execute-side state, so encoding never matters
  assign accept = (state_ff == ST_RUN) & hp_valid & ~branch_busy & ~mem_stall_i;
  assign overhead = float_variant_i ? OVERHEAD_FLOAT : OVERHEAD_FIXED;
  assign latency = float_variant_i ? LATENCY_FLOAT : LATENCY_FIXED;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    nxt_idx = idx_ff;
    nxt_line_prev = irq_line_i;
    nxt_flag = flag_ff;
    nxt_ier = enable_mask_wr_i ? enable_mask_wr_data_i : ier_ff;
    nxt_gie = gie_ff;
    nxt_saved_global_enable = saved_global_enable_ff;
    nxt_unmaskable_enable = unmaskable_enable_ff;
    nxt_in_nmi = in_nmi_ff;
    nxt_irp = return_ptr_wr_i ? return_ptr_wr_data_i : irp_ff;
    nxt_nrp = nrp_ff;
    nxt_vbase = vec_base_wr_i ? vec_base_wr_data_i : vbase_ff;
    nxt_br_hist = {br_hist_ff[1:0], branch_in_e1_i};
    nxt_slot = branch_in_e1_i ? BRANCH_DELAY_SLOTS : (slot_ff != 3'h0 ? slot_ff - 3'h1 : 3'h0);
    nxt_tgt = tgt_ff;
    nxt_fbr = 1'b0;
    nxt_ack = 1'b0;
    nxt_svc = 1'b0;
    nxt_btgt = branch_pc_i + {{(ADDR_W-BRANCH_OFFSET_W){branch_disp_i[BRANCH_OFFSET_W-1]}}, branch_disp_i};
    nxt_pred = (pred_sel_i < 3'(NUM_PRED_REGS)) ?
      (pred_nonzero_i[pred_sel_i] ^ pred_invert_i) : 1'b0;
    // global enable sits in bit 0 of the status word written by software
    if (ctl_wr_i) begin
      nxt_gie = return_ptr_wr_data_i[GIE_BIT];
      nxt_saved_global_enable = return_ptr_wr_data_i[SAVED_GLOBAL_ENABLE_BIT];
    end
    if (ret_maskable_i) begin
      nxt_gie = saved_global_enable_ff;
    end
    if (ret_unmaskable_i) begin
      nxt_unmaskable_enable = 1'b1;
      nxt_in_nmi = 1'b0;
    end
    if (unmaskable_enable_set_i) begin
      nxt_unmaskable_enable = 1'b1;
    end
    // software clear first, hardware set afterwards so an arrival survives
    if (flag_clear_wr_i) begin
      nxt_flag = nxt_flag & ~flag_clear_reg_i;
    end
    unique case (state_ff)
      ST_RUN: begin
        if (accept) begin
          nxt_state = ST_ENTER;
          nxt_cyc = 5'h01;
          nxt_idx = hp_idx;
          // packet in first execute phase is the resume point; after the first cycle of a multicycle nop, the next one is
          nxt_tgt = (multicycle_nop_i & ~nop_first_cycle_i) ? next_packet_addr_i : e1_packet_addr_i;
          if (hp_idx == LINE_UNMASKABLE) begin
            nxt_unmaskable_enable = 1'b0;
            nxt_in_nmi = 1'b1;
            nxt_nrp = nxt_tgt;
          end else begin
            nxt_saved_global_enable = gie_ff;
            nxt_gie = 1'b0;
            nxt_irp = nxt_tgt;
          end
        end
      end
      ST_ENTER: begin
        // a stall freezes the sequence counter, stretching entry
        if (!mem_stall_i) begin
          nxt_cyc = cyc_ff + 5'h01;
          if (cyc_ff == overhead - 5'h01) begin
            nxt_fbr = 1'b1;
            nxt_ack = 1'b1;
          end
          if (cyc_ff == FLAG_CLEAR_CYCLE - 5'h01) begin
            nxt_flag[idx_ff] = 1'b0;
          end
          if (cyc_ff == latency - LATENCY_OFFSET) begin
            nxt_svc = 1'b1;
            nxt_state = ST_RUN;
          end
        end
      end
      ST_RESET_ENTRY: begin
        if (!mem_stall_i) begin
          nxt_cyc = cyc_ff + 5'h01;
          // vector branch one cycle ahead of service, so the hold still covers it
          if (cyc_ff == LATENCY_RESET - 5'h02) begin
            nxt_fbr = 1'b1;
            nxt_ack = 1'b1;
          end
          if (cyc_ff == LATENCY_RESET - 5'h01) begin
            nxt_svc = 1'b1;
            nxt_state = ST_RUN;
          end
        end
      end
      default: nxt_state = ST_RUN;
    endcase
    nxt_flag = nxt_flag | rise;
    if (reset_vector_req_i) begin
      nxt_state = ST_RESET_ENTRY;
      nxt_cyc = 5'h00;
      nxt_idx = LINE_RESET;
      nxt_gie = 1'b0;
      nxt_unmaskable_enable = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_RESET_ENTRY;
      cyc_ff <= 5'h00;
      idx_ff <= 4'h0;
      line_prev_ff <= '1;
      flag_ff <= '0;
      ier_ff <= 16'h0001;
      gie_ff <= 1'b0;
      saved_global_enable_ff <= 1'b0;
      unmaskable_enable_ff <= 1'b0;
      in_nmi_ff <= 1'b0;
      irp_ff <= RETURN_RESET;
      nrp_ff <= RETURN_RESET;
      vbase_ff <= 22'h000000;
      br_hist_ff <= 3'h0;
      slot_ff <= 3'h0;
      tgt_ff <= RETURN_RESET;
      fbr_ff <= 1'b0;
      ack_ff <= 1'b0;
      svc_ff <= 1'b0;
      btgt_ff <= RETURN_RESET;
      pred_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      idx_ff <= nxt_idx;
      line_prev_ff <= nxt_line_prev;
      flag_ff <= nxt_flag;
      ier_ff <= {nxt_ier[NUM_LINES-1:1], 1'b1};
      gie_ff <= nxt_gie;
      saved_global_enable_ff <= nxt_saved_global_enable;
      unmaskable_enable_ff <= nxt_unmaskable_enable;
      in_nmi_ff <= nxt_in_nmi;
      irp_ff <= nxt_irp;
      nrp_ff <= nxt_nrp;
      vbase_ff <= nxt_vbase;
      br_hist_ff <= nxt_br_hist;
      slot_ff <= nxt_slot;
      tgt_ff <= nxt_tgt;
      fbr_ff <= nxt_fbr;
      ack_ff <= nxt_ack;
      svc_ff <= nxt_svc;
      btgt_ff <= nxt_btgt;
      pred_ff <= nxt_pred;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // hold and annul cover the whole overhead window
  assign issue_hold_o = (state_ff != ST_RUN);
  assign annul_o = (state_ff == ST_ENTER) & (cyc_ff <= overhead);
  assign pending_flag_reg_o = flag_ff;
  assign enable_mask_reg_o = ier_ff;
  assign global_mask_enable_o = gie_ff;
  assign saved_global_enable_o = saved_global_enable_ff;
  assign unmaskable_enable_o = unmaskable_enable_ff;
  assign maskable_return_pointer_o = irp_ff;
  assign unmaskable_return_pointer_o = nrp_ff;
  // index field shows the best pending line; zero when no enabled flag pends
  assign vector_table_pointer_o = {vbase_ff, 1'b0, (poll_valid ? poll_idx : 4'h0), 5'h00};
  assign control_status_reg_o = {30'h0, saved_global_enable_ff, gie_ff};
  assign force_branch_o = fbr_ff;
  assign force_target_o = {vbase_ff, 1'b0, idx_ff, 5'h00};
  assign ack_o = ack_ff;
  assign ack_index_o = idx_ff;
  assign service_start_o = svc_ff;
  assign pred_true_o = pred_ff;
  assign branch_target_o = btgt_ff;
endmodule : irq_accept
`default_nettype wire

//--- dv/irq_accept_checker.sv
`timescale 1ns/10ps
`default_nettype none
module irq_accept_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic float_variant_i,
  input wire logic mem_stall_i,
  input wire logic [15:0] irq_line_i,
  input wire logic ret_maskable_i,
  input wire logic ctl_wr_i,
  input wire logic [15:0] pending_flag_reg_o,
  input wire logic global_mask_enable_o,
  input wire logic saved_global_enable_o,
  input wire logic unmaskable_enable_o,
  input wire logic [31:0] control_status_reg_o,
  input wire logic issue_hold_o,
  input wire logic force_branch_o,
  input wire logic ack_o,
  input wire logic [3:0] ack_index_o
);
  // ****************************************
  // entry sequencing checks
  // ****************************************
  logic [15:0] prev_ff;
  logic [15:0] rise;
  // last sampled levels; a flag needs a low sample before the high one
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) prev_ff <= '0;
    else prev_ff <= irq_line_i;
  end
  // line 0 is the reset slot; its pin edges are left out of this check
  assign rise = irq_line_i & ~prev_ff & 16'hFFFE;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence sq_entry;
    $rose(issue_hold_o) && !float_variant_i;
  endsequence
  sequence sq_vector;
    ack_o && force_branch_o;
  endsequence
  AST_FLAG_SET: assert property (rise != 0 |=> (pending_flag_reg_o & $past(rise)) == $past(rise))
    else $error("edge did not set its flag");
  // stalls stretch the entry, so the fixed window only holds without them
  AST_ENTRY_TIME: assert property (disable iff (sys_rst_i || mem_stall_i) sq_entry |-> ##[5:7] sq_vector)
    else $error("vector branch not on time");
  AST_ACK_HOLD: assert property (ack_o |-> issue_hold_o)
    else $error("issue not held at vector branch");
  AST_FLAG_CLEAR: assert property (ack_o && ack_index_o != 4'h0 |-> ##[1:2] !pending_flag_reg_o[ack_index_o])
    else $error("serviced flag not cleared");
  AST_MASK_SAVE: assert property (ack_o && ack_index_o > 4'h1 |-> !global_mask_enable_o && saved_global_enable_o)
    else $error("global enable not saved and cleared");
  AST_NMI_CLEAR: assert property (ack_o && ack_index_o == 4'h1 |-> !unmaskable_enable_o)
    else $error("unmaskable enable not cleared");
  AST_ACCEPT_UNMASKABLE_ENABLE: assert property ($rose(issue_hold_o) |-> $past(unmaskable_enable_o))
    else $error("accepted with unmaskable enable low");
  AST_GIE_ACCEPT: assert property ($rose(issue_hold_o) && !$past(global_mask_enable_o)
    |-> ##[5:9] (ack_o && ack_index_o == 4'h1))
    else $error("maskable line taken with global enable low");
  AST_RESTORE: assert property (ret_maskable_i && !ctl_wr_i |=> global_mask_enable_o == $past(saved_global_enable_o))
    else $error("return did not restore global enable");
  AST_CSR: assert property (control_status_reg_o[1:0] == {saved_global_enable_o, global_mask_enable_o})
    else $error("status bits misplaced");
endmodule : irq_accept_checker
`default_nettype wire

//--- dv/irq_source_model.sv
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] fire_i,
  output logic [15:0] irq_line_o
);
  // ****************************************
  // request lines of peripherals and pins
  // ****************************************
  logic [15:0] nxt_line;
  // a line only rises out of a low cycle, so requests come spaced
  always_comb nxt_line = fire_i & ~irq_line_o;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) irq_line_o <= '0;
    else irq_line_o <= nxt_line;
  end
endmodule : irq_source_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
bind irq_accept irq_accept_checker irq_accept_checker_i (.clk_i, .sys_rst_i, .float_variant_i, .mem_stall_i, .irq_line_i,
  .ret_maskable_i, .ctl_wr_i, .pending_flag_reg_o, .global_mask_enable_o, .saved_global_enable_o, .unmaskable_enable_o,
  .control_status_reg_o, .issue_hold_o, .force_branch_o, .ack_o, .ack_index_o);
module tb;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic clk_i = 0, sys_rst_i = 1, float_variant_i = 0, reset_vector_req_i = 0, mem_stall_i = 0, branch_in_e1_i = 0;
  logic multicycle_nop_i = 0, nop_first_cycle_i = 0, ctl_wr_i = 0, enable_mask_wr_i = 0, flag_clear_wr_i = 0;
  logic return_ptr_wr_i = 0, vec_base_wr_i = 0, ret_maskable_i = 0, ret_unmaskable_i = 0, unmaskable_enable_set_i = 0;
  logic pred_invert_i = 0;
  logic [31:0] e1_packet_addr_i = 32'h0000_0100, next_packet_addr_i = 32'h0000_0120;
  logic [31:0] return_ptr_wr_data_i = '0, branch_pc_i = 32'h0000_1000;
  logic [15:0] enable_mask_wr_data_i = '0, flag_clear_reg_i = '0, fire = '0, irq_line_i;
  logic [21:0] vec_base_wr_data_i = '0;
  logic [4:0] pred_nonzero_i = '0;
  logic [2:0] pred_sel_i = '0;
  logic [20:0] branch_disp_i = 21'h1F_FFFC;
  logic [15:0] pending_flag_reg_o, enable_mask_reg_o;
  logic [31:0] maskable_return_pointer_o, unmaskable_return_pointer_o, vector_table_pointer_o, control_status_reg_o;
  logic global_mask_enable_o, saved_global_enable_o, unmaskable_enable_o, issue_hold_o, ack_o, force_branch_o;
  logic service_start_o, pred_true_o, annul_o;
  logic [31:0] force_target_o, branch_target_o;
  logic [3:0] ack_index_o;
  int bad_count = 0, comparisons = 0, cyc = 0, n, n0;
  irq_accept irq_accept_i (.clk_i, .sys_rst_i, .float_variant_i, .irq_line_i, .reset_vector_req_i, .mem_stall_i,
    .branch_in_e1_i, .multicycle_nop_i, .nop_first_cycle_i, .e1_packet_addr_i, .next_packet_addr_i, .ctl_wr_i,
    .enable_mask_wr_data_i, .enable_mask_wr_i, .flag_clear_reg_i, .flag_clear_wr_i, .return_ptr_wr_data_i,
    .return_ptr_wr_i, .vec_base_wr_data_i, .vec_base_wr_i, .ret_maskable_i, .ret_unmaskable_i,
    .unmaskable_enable_set_i, .pred_nonzero_i, .pred_sel_i, .pred_invert_i, .branch_disp_i, .branch_pc_i,
    .pending_flag_reg_o, .enable_mask_reg_o, .global_mask_enable_o, .saved_global_enable_o, .unmaskable_enable_o,
    .maskable_return_pointer_o, .unmaskable_return_pointer_o, .vector_table_pointer_o, .control_status_reg_o,
    .issue_hold_o, .annul_o, .force_branch_o, .force_target_o, .ack_o, .ack_index_o, .service_start_o,
    .pred_true_o, .branch_target_o);
  irq_source_model irq_source_model_i (.clk_i, .sys_rst_i, .fire_i(fire), .irq_line_o(irq_line_i));
  always #4 clk_i = ~clk_i;
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // whole run is about 150 cycles; the ceiling leaves wide margin
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  // inputs always move 1 ns after the edge
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask : pulse
  // fire lines, optional branch beside them and a stall after acceptance
  task automatic fire_wait(input logic [15:0] m, input int st, input logic br, output int cnt);
    fire = m;
    branch_in_e1_i = br;
    step(1);
    fire = '0;
    branch_in_e1_i = 0;
    cnt = 0;
    while (!ack_o && cnt < 60) begin
      mem_stall_i = (cnt >= 4 && cnt < 4 + st);
      step(1);
      cnt++;
    end
    mem_stall_i = 0;
    `CHK("ack", 1'b1, ack_o)
  endtask : fire_wait
  initial begin
    step(4);
    `CHK("ier", 16'h0001, enable_mask_reg_o)
    `CHK("enables", 3'b000, {global_mask_enable_o, saved_global_enable_o, unmaskable_enable_o})
    sys_rst_i = 0;
    n = 0;
    while (!service_start_o && n < 40) begin
      step(1);
      n++;
    end
    `CHK("reset latency", 21, n)
    pulse(unmaskable_enable_set_i);
    enable_mask_wr_data_i = 16'h0032;
    pulse(enable_mask_wr_i);
    vec_base_wr_data_i = 22'h00_0003;
    pulse(vec_base_wr_i);
    // global enable still low: flags pend for polling
    fire = 16'h0030;
    step(1);
    fire = '0;
    step(4);
    `CHK("flags", 16'h0030, pending_flag_reg_o & 16'h0030)
    `CHK("vector", {22'h00_0003, 5'h04, 5'h00}, vector_table_pointer_o)
    flag_clear_reg_i = 16'h0010;
    pulse(flag_clear_wr_i);
    `CHK("flags", 16'h0020, pending_flag_reg_o & 16'h0030)
    `CHK("vector", {22'h00_0003, 5'h05, 5'h00}, vector_table_pointer_o)
    flag_clear_reg_i = 16'h0020;
    pulse(flag_clear_wr_i);
    return_ptr_wr_data_i = 32'hCAFE_0040;
    pulse(return_ptr_wr_i);
    `CHK("irp", 32'hCAFE_0040, maskable_return_pointer_o)
    return_ptr_wr_data_i = 32'h0000_0001;
    pulse(ctl_wr_i);
    `CHK("csr", 32'h0000_0001, control_status_reg_o)
    fire_wait(16'h0020, 0, 0, n0);
    `CHK("index", 4'h5, ack_index_o)
    `CHK("irp", e1_packet_addr_i, maskable_return_pointer_o)
    `CHK("gie saved_global_enable", 2'b01, {global_mask_enable_o, saved_global_enable_o})
    `CHK("vector branch", 32'h0000_0CA0, force_target_o)
    `CHK("annul", 1'b1, annul_o)
    step(6);
    fire = 16'h0010;
    step(1);
    fire = '0;
    fire_wait(16'h0002, 0, 0, n);
    `CHK("index", 4'h1, ack_index_o)
    `CHK("nrp", e1_packet_addr_i, unmaskable_return_pointer_o)
    step(6);
    pulse(ctl_wr_i);
    step(10);
    `CHK("nmi not preempted", 1'b1, pending_flag_reg_o[4])
    multicycle_nop_i = 1;
    pulse(ret_unmaskable_i);
    fire_wait(16'h0000, 0, 0, n);
    multicycle_nop_i = 0;
    `CHK("index", 4'h4, ack_index_o)
    `CHK("irp", next_packet_addr_i, maskable_return_pointer_o)
    step(6);
    pulse(ret_maskable_i);
    `CHK("gie", 1'b1, global_mask_enable_o)
    float_variant_i = 1;
    fire_wait(16'h0020, 0, 0, n);
    `CHK("float overhead", n0 + 2, n)
    step(6);
    float_variant_i = 0;
    pulse(ret_maskable_i);
    fire_wait(16'h0020, 3, 0, n);
    `CHK("stalled entry", n0 + 3, n)
    step(6);
    pulse(ret_maskable_i);
    fire_wait(16'h0020, 0, 1, n);
    `CHK("branch defers", 1'b1, n > n0)
    // each of the five predicate registers drives the condition
    for (int i = 0; i < 5; i++) begin
      pred_nonzero_i = 5'(1 << i);
      pred_sel_i = 3'(i);
      step(1);
      `CHK("pred", 1'b1, pred_true_o)
    end
    pred_invert_i = 1;
    step(1);
    `CHK("pred inverted", 1'b0, pred_true_o)
    `CHK("branch target", 32'h0000_0FFC, branch_target_o)
    wrap_up();
  end
endmodule : tb
`default_nettype wire
